// ==== src/swc_consts.vh ====
// register offset, field positions and reset values of the switch control block
`ifndef SWC_CONSTS_VH
`define SWC_CONSTS_VH
`define SWC_SWITCH_CONTROL_ADDR 12'h32c
`define SWC_FUNDAMENTAL_RESET_TRIGGER_BIT      0
`define SWC_HOT_RESET_TRIGGER_BIT      1
`define SWC_HOLD_BIT      2
`define SWC_UNLOCK_BIT    3
`define SWC_PBUNLOCK_BIT  4
`define SWC_LDHRDIS_BIT   5
`define SWC_EESKIP_BIT    6
`define SWC_ORDDIS_BIT    7
`define SWC_P2PDIS_BIT    8
`define SWC_CUT_THROUGH_DISABLE_BIT     14
`define SWC_LOCKIGN_BIT   15
`define SWC_WAKE_DIRECTION_BIT   16
`define SWC_AUXEN_BIT     17
`define SWC_BCDISC_BIT    18
`define SWC_RESET_VALUE   32'h0000_0000
`define SWC_RST_PULSE_CYC 4'h4
`endif

// ==== src/swc_switch_control.v ====
// switch control register with apb slave and reset sequencing hooks
//
// Chosen here: the APB register port.
module swc_switch_control #(
  parameter RST_PULSE_CYC = 4
) (
  input  wire        mclk_in,            // 100 MHz clock
  input  wire        rst_in,             // async reset, active high, aux power-on
  input  wire        psel_in,            // apb select
  input  wire        penable_in,         // apb enable
  input  wire        pwrite_in,          // apb direction
  input  wire [11:0] paddr_in,           // apb byte address
  input  wire [31:0] pwdata_in,          // apb write data
  output reg  [31:0] prdata_out,         // apb read data
  output reg         pready_out,         // apb ready
  output reg         pslverr_out,        // apb error, unmapped address
  input  wire        aux_power_disable_pin_in, // active-high strap pin, high disables aux power
  input  wire        ee_init_active_in,  // eeprom init in progress
  input  wire        ee_init_error_in,   // eeprom init error pulse
  input  wire        ee_hold_set_in,     // eeprom code sets hold bit
  input  wire        link_down_in,       // upstream link entered dl_down
  input  wire        hot_reset_req_in,   // other hot reset cause
  output reg         fundamental_reset_out, // fundamental reset pulse
  output reg         hot_reset_out,      // hot reset pulse
  output reg         switch_reset_out,   // switch core held in reset
  output reg         reset_active_out,   // reset sequence in progress
  output reg         hot_eeprom_init_out, // run eeprom init in hot reset
  output reg         register_unlock_out, // lockable fields writable
  output reg         power_budget_data_unlock_out, // budget data writable
  output reg         ordering_disable_out, // strict ordering
  output reg         peer_to_peer_disable_out, // p2p as unsupported
  output reg         cut_through_disable_out, // store-and-forward
  output reg         lock_ignore_a_out,  // ignore locked semantics
  output reg         wake_pin_oe_n_out,  // low while wake pin driven
  output reg         aux_power_enable_out, // aux power use allowed
  output reg         broadcast_discard_out // drop vendor broadcasts
);
`include "swc_consts.vh"

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_PULSE = 2'h1;
  localparam ST_INIT = 2'h2;
  localparam ST_HOLD = 2'h3;

  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [3:0]  cnt_reg;
  reg  [3:0]  cnt_next;
  reg         hot_kind_reg;
  reg         hot_kind_next;
  reg         hold_reg;
  reg         unlock_reg;
  reg         pbunlock_reg;
  reg         ldhrdis_reg;
  reg         eeskip_reg;
  reg         orddis_reg;
  reg         p2pdis_reg;
  reg         cut_through_disable_reg;
  reg         lockign_reg;
  reg         bcdisc_reg;
  reg         wake_direction_reg;
  reg         auxen_reg;
  reg         strap_done_reg;
  reg  [1:0]  pin_sync_reg;
  reg  [1:0]  ldn_sync_reg;
  wire        wr_acc;
  wire        hit;
  wire        fundamental_reset_trigger_req;
  wire        hot_reset_trigger_req;
  wire [31:0] rd_val;

  assign hit = (paddr_in == `SWC_SWITCH_CONTROL_ADDR);
  assign wr_acc = psel_in & penable_in & pwrite_in & hit;
  assign fundamental_reset_trigger_req = wr_acc & pwdata_in[`SWC_FUNDAMENTAL_RESET_TRIGGER_BIT];
  // link-down cause suppressed when disabled
  assign hot_reset_trigger_req = (wr_acc & pwdata_in[`SWC_HOT_RESET_TRIGGER_BIT]) | hot_reset_req_in
                    | (ldn_sync_reg[1] & ~ldhrdis_reg);

  // ---------------------------------------------------------------
  // read value of the control word
  // ---------------------------------------------------------------
  // trigger bits read zero; reserved zero
  assign rd_val[`SWC_FUNDAMENTAL_RESET_TRIGGER_BIT]     = 1'b0;
  assign rd_val[`SWC_HOT_RESET_TRIGGER_BIT]     = 1'b0;
  assign rd_val[`SWC_HOLD_BIT]     = hold_reg;
  assign rd_val[`SWC_UNLOCK_BIT]   = unlock_reg;
  assign rd_val[`SWC_PBUNLOCK_BIT] = pbunlock_reg;
  assign rd_val[`SWC_LDHRDIS_BIT]  = ldhrdis_reg;
  assign rd_val[`SWC_EESKIP_BIT]   = eeskip_reg;
  assign rd_val[`SWC_ORDDIS_BIT]   = orddis_reg;
  assign rd_val[`SWC_P2PDIS_BIT]   = p2pdis_reg;
  assign rd_val[13:9]              = 5'h00;
  assign rd_val[`SWC_CUT_THROUGH_DISABLE_BIT]    = cut_through_disable_reg;
  assign rd_val[`SWC_LOCKIGN_BIT]  = lockign_reg;
  assign rd_val[`SWC_WAKE_DIRECTION_BIT]  = wake_direction_reg;
  assign rd_val[`SWC_AUXEN_BIT]    = auxen_reg;
  assign rd_val[`SWC_BCDISC_BIT]   = bcdisc_reg;
  assign rd_val[31:19]             = 13'h0000;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // strap path not reset, so the pin level is settled at release
  always @(posedge mclk_in) begin
    pin_sync_reg <= {pin_sync_reg[0], aux_power_disable_pin_in};
  end

  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ldn_sync_reg <= 2'h0;
    end else begin
      ldn_sync_reg <= {ldn_sync_reg[0], link_down_in};
    end
  end

  // ---------------------------------------------------------------
  // apb slave, one wait-free access phase
  // ---------------------------------------------------------------
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      prdata_out <= 32'h0;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= psel_in & ~penable_in;
      pslverr_out <= psel_in & ~penable_in & ~hit;
      prdata_out <= (psel_in & ~penable_in & ~pwrite_in & hit) ? rd_val : 32'h0;
    end
  end

  // ---------------------------------------------------------------
  // reset sequencer
  // ---------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    hot_kind_next = hot_kind_reg;
    case (state_reg)
      ST_IDLE: begin
        cnt_next = 4'h0;
        if (fundamental_reset_trigger_req | hot_reset_trigger_req) begin
          state_next = ST_PULSE;
          hot_kind_next = ~fundamental_reset_trigger_req;
        end
      end
      ST_PULSE: begin
        cnt_next = cnt_reg + 4'h1;
        if (cnt_reg == RST_PULSE_CYC[3:0] - 4'h1) begin
          state_next = ST_INIT;
        end
      end
      ST_INIT: begin
        if (!ee_init_active_in) begin
          state_next = hold_reg ? ST_HOLD : ST_IDLE;
        end
      end
      default: begin
        if (!hold_reg) begin
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  // release of reset starts with a fundamental pulse
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= ST_PULSE;
      cnt_reg <= 4'h0;
      hot_kind_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      hot_kind_reg <= hot_kind_next;
    end
  end

  // ---------------------------------------------------------------
  // control fields
  // ---------------------------------------------------------------
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      hold_reg <= 1'b0;
      unlock_reg <= 1'b0;
      pbunlock_reg <= 1'b0;
      ldhrdis_reg <= 1'b0;
      eeskip_reg <= 1'b0;
      orddis_reg <= 1'b0;
      p2pdis_reg <= 1'b0;
      cut_through_disable_reg <= 1'b0;
      lockign_reg <= 1'b0;
      bcdisc_reg <= 1'b0;
      wake_direction_reg <= 1'b0;
      auxen_reg <= 1'b0;
      strap_done_reg <= 1'b0;
    end else begin
      if (!strap_done_reg) begin
        strap_done_reg <= 1'b1;
        auxen_reg <= ~pin_sync_reg[1];
      end else if (wr_acc) begin
        auxen_reg <= pwdata_in[`SWC_AUXEN_BIT];
      end
      // fundamental reset restores sticky fields; hot keeps them
      if (state_reg == ST_PULSE && !hot_kind_reg && cnt_reg == 4'h0) begin
        pbunlock_reg <= 1'b0;
        ldhrdis_reg <= 1'b0;
        eeskip_reg <= 1'b0;
        orddis_reg <= 1'b0;
        p2pdis_reg <= 1'b0;
        cut_through_disable_reg <= 1'b0;
        lockign_reg <= 1'b0;
        bcdisc_reg <= 1'b0;
        hold_reg <= 1'b0;
      end else if (wr_acc) begin
        if (state_reg != ST_IDLE) begin
          hold_reg <= pwdata_in[`SWC_HOLD_BIT];
        end
        if (unlock_reg) begin
          pbunlock_reg <= pwdata_in[`SWC_PBUNLOCK_BIT];
        end
        ldhrdis_reg <= pwdata_in[`SWC_LDHRDIS_BIT];
        eeskip_reg <= pwdata_in[`SWC_EESKIP_BIT];
        orddis_reg <= pwdata_in[`SWC_ORDDIS_BIT];
        p2pdis_reg <= pwdata_in[`SWC_P2PDIS_BIT];
        cut_through_disable_reg <= pwdata_in[`SWC_CUT_THROUGH_DISABLE_BIT];
        lockign_reg <= pwdata_in[`SWC_LOCKIGN_BIT];
        bcdisc_reg <= pwdata_in[`SWC_BCDISC_BIT];
        wake_direction_reg <= pwdata_in[`SWC_WAKE_DIRECTION_BIT];
      end
      if (ee_init_error_in | ee_hold_set_in) begin
        hold_reg <= 1'b1;
      end
      if (state_reg != ST_IDLE) begin
        unlock_reg <= 1'b1;
      end else if (wr_acc) begin
        unlock_reg <= pwdata_in[`SWC_UNLOCK_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      fundamental_reset_out <= 1'b1;
      hot_reset_out <= 1'b0;
      switch_reset_out <= 1'b1;
      reset_active_out <= 1'b1;
      hot_eeprom_init_out <= 1'b1;
      register_unlock_out <= 1'b0;
      power_budget_data_unlock_out <= 1'b0;
      ordering_disable_out <= 1'b0;
      peer_to_peer_disable_out <= 1'b0;
      cut_through_disable_out <= 1'b0;
      lock_ignore_a_out <= 1'b0;
      wake_pin_oe_n_out <= 1'b1;
      aux_power_enable_out <= 1'b0;
      broadcast_discard_out <= 1'b0;
    end else begin
      fundamental_reset_out <= (state_reg == ST_PULSE) & ~hot_kind_reg;
      hot_reset_out <= (state_reg == ST_PULSE) & hot_kind_reg;
      switch_reset_out <= (state_reg == ST_PULSE) | (state_reg == ST_HOLD);
      reset_active_out <= (state_reg != ST_IDLE);
      hot_eeprom_init_out <= ~eeskip_reg;
      register_unlock_out <= unlock_reg;
      power_budget_data_unlock_out <= pbunlock_reg;
      ordering_disable_out <= orddis_reg;
      peer_to_peer_disable_out <= p2pdis_reg;
      cut_through_disable_out <= cut_through_disable_reg;
      lock_ignore_a_out <= lockign_reg;
      wake_pin_oe_n_out <= ~wake_direction_reg;
      aux_power_enable_out <= auxen_reg;
      broadcast_discard_out <= bcdisc_reg;
    end
  end
endmodule // swc_switch_control

// ==== tb/swc_ctl_monitor.sv ====
// port checker of the switch control register
`include "swc_consts.vh"
module swc_ctl_monitor (
  input wire logic        mclk_in, rst_in, psel_in, penable_in, pwrite_in,
  input wire logic        pready_out, pslverr_out, fundamental_reset_out, hot_reset_out,
  input wire logic        reset_active_out, register_unlock_out,
  input wire logic        power_budget_data_unlock_out, ordering_disable_out,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in, prdata_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  wire hit = psel_in & penable_in & pready_out & pwrite_in
             & (paddr_in == `SWC_SWITCH_CONTROL_ADDR);
  wire plain = hit & ~reset_active_out & ~pwdata_in[0] & ~pwdata_in[1];
  a_ready_after_setup: assert property (psel_in && !penable_in |=> pready_out)
    else $error("no ready in access phase");
  a_read_fundamental_reset_trigger_zero: assert property (pready_out |-> !prdata_out[0])
    else $error("reset trigger bit read back set");
  a_read_hot_reset_trigger_zero: assert property (pready_out |-> !prdata_out[1])
    else $error("hot trigger bit read back set");
  a_fundamental_reset_trigger_starts: assert property (hit && pwdata_in[0] && !reset_active_out
    |-> ##[1:3] fundamental_reset_out) else $error("no fundamental reset");
  a_hot_reset_trigger_starts: assert property (hit && pwdata_in[1] && !pwdata_in[0]
    && !reset_active_out |-> ##[1:3] hot_reset_out) else $error("no hot reset");
  a_unlock_in_seq: assert property (reset_active_out [*3] |-> register_unlock_out)
    else $error("unlock low during reset sequence");
  a_reserved_zero: assert property (pready_out |-> prdata_out[13:9] == 5'h00
    && prdata_out[31:19] == 13'h0000) else $error("reserved bits read set");
  a_unmapped_err: assert property (psel_in && !penable_in
    && paddr_in != `SWC_SWITCH_CONTROL_ADDR |=> pslverr_out && prdata_out == 32'h0)
    else $error("unmapped access not refused");
  a_budget_locked: assert property (plain && !register_unlock_out
    |=> ##1 $stable(power_budget_data_unlock_out)) else $error("locked bit changed");
  a_order_follows: assert property (plain
    |=> ##1 ordering_disable_out == $past(pwdata_in[7], 2)) else $error("ordering wrong");
  c_fundamental_reset_trigger: cover property (hit && pwdata_in[0]);
  c_refused: cover property (pready_out && pslverr_out);
  c_locked_write: cover property (plain && !register_unlock_out);
endmodule // swc_ctl_monitor
bind swc_switch_control swc_ctl_monitor u_mon (.*);

// ==== tb/tb_swc_switch_control.sv ====
// self-checking bench of the switch control register
module tb_swc_switch_control;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; \
  $display("MISMATCH %0t got %h want %h", $time, a, b); end end
  localparam logic [11:0] A = 12'h32c;
  logic        mclk_in = 0, rst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0;
  logic        aux_power_disable_pin_in = 0, ee_init_active_in = 0, ee_init_error_in = 0;
  logic        ee_hold_set_in = 0, link_down_in = 0, hot_reset_req_in = 0, err;
  logic [11:0] paddr_in = 0;
  logic [31:0] pwdata_in = 0, prdata_out, rd;
  logic        pready_out, pslverr_out, fundamental_reset_out, hot_reset_out;
  logic        switch_reset_out, reset_active_out, hot_eeprom_init_out, register_unlock_out;
  logic        power_budget_data_unlock_out, ordering_disable_out, peer_to_peer_disable_out;
  logic        cut_through_disable_out, lock_ignore_a_out, wake_pin_oe_n_out;
  logic        aux_power_enable_out, broadcast_discard_out;
  int          n_mismatch = 0, n_compared = 0;
  wire [3:0]   mon = {switch_reset_out, hot_reset_out, fundamental_reset_out, reset_active_out};
  wire [9:0]   outs = {hot_eeprom_init_out, register_unlock_out, power_budget_data_unlock_out,
                       ordering_disable_out, peer_to_peer_disable_out, cut_through_disable_out,
                       lock_ignore_a_out, wake_pin_oe_n_out, aux_power_enable_out,
                       broadcast_discard_out};
  // write value beside expected read back, register unlocked at start
  logic [63:0] rows [5] = '{64'h0007_c1f8_0007_c1f8, 64'h0000_0008_0000_0008,
                            64'h0000_0010_0000_0010, 64'hfff8_3e04_0000_0010,
                            64'h0003_0028_0003_0038};
  always #5 mclk_in = ~mclk_in;
  swc_switch_control #(.RST_PULSE_CYC(4)) uut (.*);
  function automatic logic [9:0] exp_out(input logic [31:0] r);
    return {~r[6], r[3], r[4], r[7], r[8], r[14], r[15], ~r[16], r[17], r[18]};
  endfunction
  task end_sim;
    if (n_mismatch == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk_in);
    psel_in <= 1; penable_in <= 0; pwrite_in <= wr; paddr_in <= a; pwdata_in <= d;
    @(posedge mclk_in);
    penable_in <= 1;
    do begin
      @(posedge mclk_in);
      if (++k > 20) begin n_mismatch++; $display("MISMATCH %0t no ready", $time); end_sim; end
    end while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 0; penable_in <= 0;
  endtask
  task wt(input int s, input logic v);
    repeat (300) begin
      @(posedge mclk_in); #1;
      if (mon[s] === v) return;
    end
    n_mismatch++;
    $display("MISMATCH %0t wait %0d timed out", $time, s);
    end_sim;
  endtask
  initial begin
    repeat (6) @(posedge mclk_in);
    rst_in <= 0;
    wt(0, 0);
    apb(0, A, 0);
    `CHK(rd, 32'h0002_0008)
    foreach (rows[i]) begin
      apb(1, A, rows[i][63:32]);
      apb(0, A, 0);
      `CHK(rd, rows[i][31:0])
      `CHK(outs, exp_out(rows[i][31:0]))
    end
    apb(0, 12'h330, 0);
    `CHK({err, rd}, 33'h1_0000_0000)
    // fundamental reset with an init error that sets the hold
    ee_init_active_in <= 1;
    apb(1, A, 32'h0003_0029);
    wt(1, 1);
    wt(1, 0);
    @(posedge mclk_in); ee_init_error_in <= 1;
    @(posedge mclk_in); ee_init_error_in <= 0; ee_init_active_in <= 0;
    repeat (10) @(posedge mclk_in);
    #1 `CHK(switch_reset_out, 1'b1)
    apb(0, A, 0);
    `CHK(rd, 32'h0003_000c)
    apb(1, A, 32'h0003_0008);
    wt(3, 0);
    apb(1, A, 32'h0003_000c);
    repeat (4) @(posedge mclk_in);
    #1 `CHK(switch_reset_out, 1'b0)
    // link down masked, register hot reset still works
    apb(1, A, 32'h0003_0028);
    @(posedge mclk_in); link_down_in <= 1;
    repeat (10) begin
      @(posedge mclk_in); #1 `CHK(hot_reset_out, 1'b0)
    end
    apb(1, A, 32'h0003_002a);
    wt(2, 1);
    wt(0, 0);
    apb(0, A, 0);
    `CHK(rd, 32'h0003_0028)
    // aux power-on with the disable pin high
    @(posedge mclk_in); link_down_in <= 0; aux_power_disable_pin_in <= 1; rst_in <= 1;
    repeat (6) @(posedge mclk_in);
    rst_in <= 0;
    wt(0, 0);
    apb(0, A, 0);
    `CHK(rd, 32'h0000_0008)
    end_sim;
  end
endmodule // tb_swc_switch_control
